// ===== hdl/mdr_regs.sv
// register bank with sign-extended results, keyed reset and motion detection
`timescale 1ns/1ns
`include "mdr_cfg.svh"

// Functional notes
// R1: y result as low and high bytes
// R2: z result as low and high bytes
// R3: temperature result as low and high bytes
// R4: high byte upper nibble copies bit eleven
// R5: key 0x52 clears all settings immediately; code clears them one clock cycle after the key write, through o_soft_rst_ff
// R6: interrupt pins float after keyed reset
// R7: key register reads back zero
// R8: host waits half millisecond after key
// R9: axis magnitude compared with motion limit
// R10: motion limit from low byte, three bits; code uses the whole low byte plus three bits of the high byte
// R11: compare raw codes, no range scaling
// R12: motion after duration consecutive over samples
// R13: motion duration zero acts as one
// R14: wake-up mode ignores motion duration
// R15: stillness limit eleven bits, two registers
// R16: stillness after duration consecutive under samples
// R17: stillness duration low and high bytes
// R18: stillness counter reaches 65535 without wrapping
// R19: stillness duration zero acts as one
// R20: detectors run only when enable set
// R21: events set motion and stillness flags
// R22: counters restart when a sample fails
module mdr_regs #(
  parameter logic [15:0] SETTLE_CYCLES = 16'(`MDR_SETTLE_CYCLES)
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // decoded register access from the serial port
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire mdr_pkg::mdr_byte_t   i_reg_addr,
  input  wire mdr_pkg::mdr_byte_t   i_reg_wdata,
  output mdr_pkg::mdr_byte_t        o_reg_rdata_ff,
  output logic                      o_reg_rvalid_ff,
  // samples, one strobe per output sample
  input  wire logic                 i_sample_valid,
  input  wire mdr_pkg::mdr_sample_t i_x_sample,
  input  wire mdr_pkg::mdr_sample_t i_y_sample,
  input  wire mdr_pkg::mdr_sample_t i_z_sample,
  input  wire mdr_pkg::mdr_sample_t i_temp_sample,
  input  wire logic                 i_wakeup_mode,
  // status and system outputs
  output logic                      o_motion_flag_ff,
  output logic                      o_stillness_flag_ff,
  output logic                      o_soft_rst_ff,
  output logic                      o_int_hiz_ff,
  output logic                      o_settle_busy_ff
);
  import mdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic        blk_rst;              // power-up or keyed reset
  logic        key_hit;              // valid key write this cycle
  mdr_byte_t   y_low_ff;             // y result low byte
  mdr_byte_t   y_high_ff;            // y result high byte
  mdr_byte_t   z_low_ff;             // z result low byte
  mdr_byte_t   z_high_ff;            // z result high byte
  mdr_byte_t   t_low_ff;             // temperature low byte
  mdr_byte_t   t_high_ff;            // temperature high byte
  mdr_byte_t   mlim_low_ff;          // motion limit low byte
  mdr_byte_t   mlim_high_ff;         // motion limit high byte
  mdr_byte_t   mdur_ff;              // motion duration
  mdr_byte_t   slim_low_ff;          // stillness limit low byte
  mdr_byte_t   slim_high_ff;         // stillness limit high byte
  mdr_byte_t   sdur_low_ff;          // stillness duration low byte
  mdr_byte_t   sdur_high_ff;         // stillness duration high byte
  mdr_byte_t   ctrl_ff;              // detector control
  mdr_byte_t   nxt_rdata;            // read mux
  mdr_limit_t  motion_limit;         // assembled motion limit
  mdr_limit_t  stillness_limit;      // assembled stillness limit
  logic [15:0] stillness_duration;   // assembled stillness duration
  logic [7:0]  motion_target;        // duration after wake-up override
  logic [15:0] settle_cnt_ff;        // keyed reset settle timer
  logic        motion_en;            // motion detector enable
  logic        still_en;             // stillness detector enable
  logic        motion_evt;           // motion event this step
  logic        still_evt;            // stillness event this step
  logic        status_rd;            // status register read
  logic [2:0]  axis_above;           // per axis over motion limit
  logic [2:0]  axis_below;           // per axis under stillness limit
  mdr_sample_t axis_sample [3];      // axes in detection order

  ////////////////////////////////////////////////////////////////////////////
  // reset and key handling

  // keyed reset is a one-cycle pulse folded into the block reset
  always_comb begin
    key_hit = i_reg_wr && (i_reg_addr == `MDR_KEY_ADDR) && (i_reg_wdata == `MDR_KEY_CODE); // R5
    blk_rst = i_sys_rst || o_soft_rst_ff; // R5
  end

  // pulse one cycle after the key write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_soft_rst_ff <= 1'b0;
    end else begin
      o_soft_rst_ff <= key_hit; // R5
    end
  end

  // interrupt pins float until control is written again
  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      o_int_hiz_ff <= 1'b1; // R6
    end else if (i_reg_wr && i_reg_addr == `MDR_CTRL_ADDR) begin
      o_int_hiz_ff <= 1'b0;
    end
  end

  // settle window the host must respect after a keyed reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      settle_cnt_ff    <= 16'h0000;
      o_settle_busy_ff <= 1'b0;
    end else if (key_hit) begin
      settle_cnt_ff    <= SETTLE_CYCLES; // R8
      o_settle_busy_ff <= 1'b1;
    end else if (settle_cnt_ff != 16'h0000) begin
      settle_cnt_ff    <= settle_cnt_ff - 16'h0001;
      o_settle_busy_ff <= settle_cnt_ff != 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result bytes

  // capture y, z and temperature samples as sign-extended byte pairs, x is not stored
  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      y_low_ff  <= `MDR_REG_RESET;
      y_high_ff <= `MDR_REG_RESET;
      z_low_ff  <= `MDR_REG_RESET;
      z_high_ff <= `MDR_REG_RESET;
      t_low_ff  <= `MDR_REG_RESET;
      t_high_ff <= `MDR_REG_RESET;
    end else if (i_sample_valid) begin
      y_low_ff  <= i_y_sample[7:0];                             // R1
      y_high_ff <= {{4{i_y_sample[11]}}, i_y_sample[11:8]};     // R1 R4
      z_low_ff  <= i_z_sample[7:0];                             // R2
      z_high_ff <= {{4{i_z_sample[11]}}, i_z_sample[11:8]};     // R2 R4
      t_low_ff  <= i_temp_sample[7:0];                          // R3
      t_high_ff <= {{4{i_temp_sample[11]}}, i_temp_sample[11:8]}; // R3 R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // host writes, all cleared by either reset
  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      mlim_low_ff  <= `MDR_REG_RESET; // R5
      mlim_high_ff <= `MDR_REG_RESET;
      mdur_ff      <= `MDR_REG_RESET;
      slim_low_ff  <= `MDR_REG_RESET;
      slim_high_ff <= `MDR_REG_RESET;
      sdur_low_ff  <= `MDR_REG_RESET;
      sdur_high_ff <= `MDR_REG_RESET;
      ctrl_ff      <= `MDR_REG_RESET;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `MDR_MLIM_LOW_ADDR:  mlim_low_ff  <= i_reg_wdata;
        `MDR_MLIM_HIGH_ADDR: mlim_high_ff <= i_reg_wdata;
        `MDR_MDUR_ADDR:      mdur_ff      <= i_reg_wdata;
        `MDR_SLIM_LOW_ADDR:  slim_low_ff  <= i_reg_wdata;
        `MDR_SLIM_HIGH_ADDR: slim_high_ff <= i_reg_wdata;
        `MDR_SDUR_LOW_ADDR:  sdur_low_ff  <= i_reg_wdata;
        `MDR_SDUR_HIGH_ADDR: sdur_high_ff <= i_reg_wdata;
        `MDR_CTRL_ADDR:      ctrl_ff      <= i_reg_wdata;
        default:             ; // read-only, key or unmapped
      endcase
    end
  end

  // assemble multi-byte fields
  always_comb begin
    motion_limit       = {mlim_high_ff[2:0], mlim_low_ff};  // R10
    stillness_limit    = {slim_high_ff[2:0], slim_low_ff};  // R15
    stillness_duration = {sdur_high_ff, sdur_low_ff};       // R17
    motion_target      = i_wakeup_mode ? 8'h01 : mdur_ff;   // R14
    motion_en          = ctrl_ff[`MDR_CTRL_MOTION_EN];      // R20
    still_en           = ctrl_ff[`MDR_CTRL_STILL_EN];       // R20
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection

  // axes in fixed order x, y, z
  always_comb begin
    axis_sample[0] = i_x_sample;
    axis_sample[1] = i_y_sample;
    axis_sample[2] = i_z_sample;
  end

  // one comparator per axis on raw codes
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      mdr_axis_mag u_mag (
        .i_sample          (axis_sample[g]),
        .i_motion_limit    (motion_limit),    // R9 R11
        .i_stillness_limit (stillness_limit), // R15
        .o_above           (axis_above[g]),
        .o_below           (axis_below[g])
      );
    end
  endgenerate

  // any axis over starts a motion run
  mdr_run_counter #(.W(8)) u_motion_run (
    .i_clk    (i_clk),
    .i_rst    (blk_rst),
    .i_enable (motion_en),
    .i_step   (i_sample_valid),
    .i_hit    (|axis_above),     // R12
    .i_target (motion_target),   // R13 R14
    .o_event  (motion_evt)
  );

  // every axis under starts a stillness run
  mdr_run_counter #(.W(16)) u_still_run (
    .i_clk    (i_clk),
    .i_rst    (blk_rst),
    .i_enable (still_en),
    .i_step   (i_sample_valid),
    .i_hit    (&axis_below),        // R16
    .i_target (stillness_duration), // R18 R19
    .o_event  (still_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // reading status acknowledges both flags
  always_comb begin
    status_rd = i_reg_rd && (i_reg_addr == `MDR_STATUS_ADDR);
  end

  // sticky flags, a new event beats the read clear
  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      o_motion_flag_ff    <= 1'b0;
      o_stillness_flag_ff <= 1'b0;
    end else begin
      if (motion_evt) begin
        o_motion_flag_ff <= 1'b1; // R21
      end else if (status_rd) begin
        o_motion_flag_ff <= 1'b0;
      end
      if (still_evt) begin
        o_stillness_flag_ff <= 1'b1; // R21
      end else if (status_rd) begin
        o_stillness_flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // read mux, unmapped and key read as zero
  always_comb begin
    unique case (i_reg_addr)
      `MDR_STATUS_ADDR: begin
        nxt_rdata = 8'h00;
        nxt_rdata[`MDR_STAT_MOTION] = o_motion_flag_ff;
        nxt_rdata[`MDR_STAT_STILL]  = o_stillness_flag_ff;
      end
      `MDR_Y_LOW_ADDR:     nxt_rdata = y_low_ff;
      `MDR_Y_HIGH_ADDR:    nxt_rdata = y_high_ff;
      `MDR_Z_LOW_ADDR:     nxt_rdata = z_low_ff;
      `MDR_Z_HIGH_ADDR:    nxt_rdata = z_high_ff;
      `MDR_T_LOW_ADDR:     nxt_rdata = t_low_ff;
      `MDR_T_HIGH_ADDR:    nxt_rdata = t_high_ff;
      `MDR_KEY_ADDR:       nxt_rdata = `MDR_KEY_READ; // R7
      `MDR_MLIM_LOW_ADDR:  nxt_rdata = mlim_low_ff;
      `MDR_MLIM_HIGH_ADDR: nxt_rdata = mlim_high_ff;
      `MDR_MDUR_ADDR:      nxt_rdata = mdur_ff;
      `MDR_SLIM_LOW_ADDR:  nxt_rdata = slim_low_ff;
      `MDR_SLIM_HIGH_ADDR: nxt_rdata = slim_high_ff;
      `MDR_SDUR_LOW_ADDR:  nxt_rdata = sdur_low_ff;
      `MDR_SDUR_HIGH_ADDR: nxt_rdata = sdur_high_ff;
      `MDR_CTRL_ADDR:      nxt_rdata = ctrl_ff;
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // read data one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata_ff  <= 8'h00;
      o_reg_rvalid_ff <= 1'b0;
    end else begin
      o_reg_rvalid_ff <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_key_read_zero: assert property (i_reg_rd && i_reg_addr == `MDR_KEY_ADDR // R7
      |=> o_reg_rdata_ff == 8'h00 && o_reg_rvalid_ff)
    else $error("key register read was not zero");
  a_key_clears_cfg: assert property (key_hit |=> ##1 (ctrl_ff == 8'h00 && mdur_ff == 8'h00)) // R5
    else $error("keyed reset left settings");
  a_key_pins_float: assert property (key_hit |=> ##1 o_int_hiz_ff) // R6
    else $error("interrupt pins not floated");
  a_y_high_sign: assert property (i_sample_valid && !blk_rst |=> // R4
      y_high_ff == {{4{$past(i_y_sample[11])}}, $past(i_y_sample[11:8])})
    else $error("y high byte not sign extended");
  a_z_low_byte: assert property (i_sample_valid && !blk_rst |=> // R2
      z_low_ff == $past(i_z_sample[7:0]))
    else $error("z low byte wrong");
  a_t_high_sign: assert property (i_sample_valid && !blk_rst |=> // R3
      t_high_ff == {{4{$past(i_temp_sample[11])}}, $past(i_temp_sample[11:8])})
    else $error("temperature high byte not sign extended");
  a_motion_off: assert property (!motion_en |-> !motion_evt) // R20
    else $error("motion event while disabled");
  // only a fresh run fires, a run already past its event stays quiet
  a_wake_single: assert property (i_wakeup_mode && motion_en && i_sample_valid // R14
      && |axis_above && u_motion_run.count_ff == 8'h00 |-> motion_evt)
    else $error("wake-up mode did not trigger on one sample");
  a_motion_flag_set: assert property (motion_evt |=> o_motion_flag_ff) // R21
    else $error("motion flag not set");
  a_still_flag_set: assert property (still_evt && status_rd |=> o_stillness_flag_ff) // R21
    else $error("stillness flag lost to clear");
  a_settle_time: assert property (key_hit |=> o_settle_busy_ff[*8]) // R8
    else $error("settle window too short");

endmodule : mdr_regs

// ===== include/mdr_cfg.svh
// register map, field positions, reset values and timing for motion detection
`ifndef MDR_CFG_SVH
`define MDR_CFG_SVH

// register offsets
`define MDR_STATUS_ADDR       8'h0b
`define MDR_Y_LOW_ADDR        8'h10
`define MDR_Y_HIGH_ADDR       8'h11
`define MDR_Z_LOW_ADDR        8'h12
`define MDR_Z_HIGH_ADDR       8'h13
`define MDR_T_LOW_ADDR        8'h14
`define MDR_T_HIGH_ADDR       8'h15
`define MDR_KEY_ADDR          8'h1f
`define MDR_MLIM_LOW_ADDR     8'h20
`define MDR_MLIM_HIGH_ADDR    8'h21
`define MDR_MDUR_ADDR         8'h22
`define MDR_SLIM_LOW_ADDR     8'h23
`define MDR_SLIM_HIGH_ADDR    8'h24
`define MDR_SDUR_LOW_ADDR     8'h25
`define MDR_SDUR_HIGH_ADDR    8'h26
`define MDR_CTRL_ADDR         8'h27

// reset key and reset values
`define MDR_KEY_CODE          8'h52
`define MDR_REG_RESET         8'h00
`define MDR_KEY_READ          8'h00

// field positions
`define MDR_CTRL_MOTION_EN    0
`define MDR_CTRL_STILL_EN     2
`define MDR_STAT_MOTION       4
`define MDR_STAT_STILL        5

// settle time after keyed reset
`define MDR_SETTLE_NS         500000
`define MDR_CLK_PERIOD_NS     20
`define MDR_SETTLE_CYCLES     ((`MDR_SETTLE_NS + `MDR_CLK_PERIOD_NS - 1) / `MDR_CLK_PERIOD_NS)

`endif

// ===== include/mdr_pkg.sv
// types shared by the motion detection register bank
package mdr_pkg;

  typedef logic signed [11:0] mdr_sample_t;   // 12-bit signed result
  typedef logic        [10:0] mdr_limit_t;    // 11-bit unsigned threshold
  typedef logic        [7:0]  mdr_byte_t;     // register byte

endpackage : mdr_pkg

// ===== hdl/mdr_axis_mag.sv
// magnitude of one axis sample compared with both thresholds
`timescale 1ns/1ns

module mdr_axis_mag (
  // sample and limits
  input  wire mdr_pkg::mdr_sample_t i_sample,
  input  wire mdr_pkg::mdr_limit_t  i_motion_limit,
  input  wire mdr_pkg::mdr_limit_t  i_stillness_limit,
  // compare results
  output logic                      o_above,
  output logic                      o_below
);
  import mdr_pkg::*;

  logic [11:0] mag;   // absolute value, 2048 fits in 12 bits

  // raw codes only, no range scaling
  always_comb begin
    mag     = i_sample[11] ? 12'(-i_sample) : 12'(i_sample);
    o_above = mag > {1'b0, i_motion_limit};
    o_below = mag < {1'b0, i_stillness_limit};
  end

endmodule : mdr_axis_mag

// ===== hdl/mdr_run_counter.sv
// consecutive qualifying sample counter with saturation
`timescale 1ns/1ns

module mdr_run_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // sample step
  input  wire logic         i_enable,
  input  wire logic         i_step,
  input  wire logic         i_hit,
  input  wire logic [W-1:0] i_target,
  // event pulse, combinational on the qualifying step
  output logic              o_event
);

  logic [W-1:0] count_ff;   // qualifying samples so far
  logic [W-1:0] eff_target; // zero treated as one

  // zero duration acts as one
  always_comb begin
    eff_target = (i_target == '0) ? W'(1) : i_target;
    o_event    = i_enable && i_step && i_hit && (count_ff == eff_target - W'(1));
  end

  // count runs, restart on a miss, saturate at full scale
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable) begin
      count_ff <= '0;
    end else if (i_step) begin
      if (!i_hit) begin
        count_ff <= '0;
      end else if (count_ff != '1) begin
        count_ff <= count_ff + W'(1);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_run_restart: assert property (i_enable && i_step && !i_hit |=> count_ff == '0) // R22
    else $error("run counter did not restart on a miss");
  a_run_nowrap: assert property (i_step && i_hit && count_ff == '1 && i_enable |=> count_ff == '1) // R18
    else $error("run counter wrapped");

endmodule : mdr_run_counter

// ===== tb/mdr_host_model.sv
// host model issuing decoded register accesses to the bank
`timescale 1ns/1ns
`include "mdr_cfg.svh"

module mdr_host_model (
  // clock and answer from the device
  input  wire logic               i_clk,
  input  wire logic               i_rvalid,
  input  wire mdr_pkg::mdr_byte_t i_rdata,
  input  wire logic               i_busy,
  // request to the device
  output logic                    o_wr,
  output logic                    o_rd,
  output mdr_pkg::mdr_byte_t      o_addr,
  output mdr_pkg::mdr_byte_t      o_wdata
);
  import mdr_pkg::*;

  // idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // one write strobe; released lines flip so no stale value lingers
  task automatic wr(input mdr_byte_t a, input mdr_byte_t d);
    int n;
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    // after the key, keep off the bus until settling ends
    if (a == 8'h1f && d == 8'h52) begin
      n = 0;
      repeat (3) @(negedge i_clk);
      while (i_busy !== 1'b0 && n < 200) begin
        @(negedge i_clk);
        n++;
      end
    end
  endtask : wr

  // one read strobe, data taken while valid stands
  task automatic rd(input mdr_byte_t a, output mdr_byte_t d);
    int n;
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    n = 0;
    while (i_rvalid !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask : rd

endmodule : mdr_host_model

// ===== tb/mdr_regs_tb.sv
// self-checking bench for the motion detection register bank
`timescale 1ns/1ns

module mdr_regs_tb;
  import mdr_pkg::*;

  ////////////////////////////////////////
  // signals
  logic        clk;        // 50 MHz clock
  logic        sys_rst;    // sync reset
  logic        valid;      // sample strobe
  logic        wake;       // wake-up mode level
  mdr_sample_t x, y, z, t; // sample inputs
  logic        wr, rd, rvalid, mflag, sflag, srst, hiz, busy;
  mdr_byte_t   addr, wdata, rdata, d;
  mdr_sample_t v;
  int          miscompares;
  int          cmp_count;
  // reset-value addresses, unmapped 0x30 included
  mdr_byte_t   ra[17] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1f, 8'h20,
                          8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h0b, 8'h30};
  mdr_sample_t rv[3] = '{12'h801, 12'h7fe, 12'h0c3};
  // motion run: hits, an equal-magnitude miss, then three hits
  mdr_sample_t mx[6] = '{12'h000, 12'heff, 12'hf00, 12'h000, 12'h000, 12'h7ff};
  mdr_sample_t my[6] = '{12'h101, 12'h000, 12'h100, 12'h000, 12'heff, 12'h000};
  mdr_sample_t mz[6] = '{12'h000, 12'h000, 12'h000, 12'h101, 12'h000, 12'h000};
  logic        me[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // stillness run: hit, equal-magnitude miss, two hits
  mdr_sample_t sx[4] = '{12'h005, 12'h005, 12'hff5, 12'h005};
  mdr_sample_t sz[4] = '{12'h005, 12'hff0, 12'h005, 12'hffb};
  logic        se[4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  ////////////////////////////////////////
  // clock, design and host
  initial clk = 1'b0;
  always #10 clk = ~clk;

  mdr_regs #(.SETTLE_CYCLES(16'd16)) u_dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata_ff(rdata),
    .o_reg_rvalid_ff(rvalid), .i_sample_valid(valid), .i_x_sample(x),
    .i_y_sample(y), .i_z_sample(z), .i_temp_sample(t), .i_wakeup_mode(wake),
    .o_motion_flag_ff(mflag), .o_stillness_flag_ff(sflag), .o_soft_rst_ff(srst),
    .o_int_hiz_ff(hiz), .o_settle_busy_ff(busy));

  mdr_host_model u_host (
    .i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .i_busy(busy),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  ////////////////////////////////////////
  // helpers
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic rchk(input mdr_byte_t a, input mdr_byte_t e);
    mdr_byte_t q;
    u_host.rd(a, q);
    chk(q, e);
  endtask : rchk

  // one sample strobe; inputs flip once it is taken
  task automatic smp(input mdr_sample_t a, b, c, e);
    @(negedge clk);
    valid = 1'b1;
    x = a;
    y = b;
    z = c;
    t = e;
    @(negedge clk);
    valid = 1'b0;
    x = ~a;
    y = ~b;
    z = ~c;
    t = ~e;
  endtask : smp

  // flags one cycle after the sample edge
  task automatic flg(input logic m, input logic s);
    @(negedge clk);
    chk({6'h0, sflag, mflag}, {6'h0, s, m});
  endtask : flg

  function automatic mdr_byte_t hb(input mdr_sample_t s);
    return {{4{s[11]}}, s[11:8]};
  endfunction : hb

  function automatic mdr_byte_t rwv(input mdr_byte_t a);
    return (a == 8'h21 || a == 8'h24) ? {5'h0, a[2:0] ^ 3'h5} : a ^ 8'ha5;
  endfunction : rwv

  // watchdog well past the expected run, the full-scale stillness run dominates
  initial begin
    #(20 * 90000);
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    valid = 1'b0;
    wake = 1'b0;
    {x, y, z, t} = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    // reset values, key and unmapped read zero
    foreach (ra[i]) rchk(ra[i], 8'h00);
    chk({7'h0, hiz}, 8'h01);
    // result bytes with sign copies
    foreach (rv[i]) begin
      smp(12'h000, rv[i], ~rv[i], rv[i] ^ 12'h00f);
      v = rv[i];
      rchk(8'h10, v[7:0]);
      rchk(8'h11, hb(v));
      v = ~rv[i];
      rchk(8'h12, v[7:0]);
      rchk(8'h13, hb(v));
      v = rv[i] ^ 12'h00f;
      rchk(8'h14, v[7:0]);
      rchk(8'h15, hb(v));
    end
    // read-only result ignores writes
    u_host.wr(8'h10, 8'h5a);
    rchk(8'h10, 8'hc3);
    // settings write then read back, no aliasing
    for (int i = 0; i < 7; i++) u_host.wr(8'h20 + 8'(i), rwv(8'h20 + 8'(i)));
    for (int i = 0; i < 7; i++) rchk(8'h20 + 8'(i), rwv(8'h20 + 8'(i)));
    // wrong key leaves settings alone
    u_host.wr(8'h1f, 8'h51);
    rchk(8'h1f, 8'h00);
    rchk(8'h20, rwv(8'h20));
    // motion run, limit 0x100, duration 3
    u_host.wr(8'h27, 8'h01);
    chk({7'h0, hiz}, 8'h00);
    u_host.wr(8'h20, 8'h00);
    u_host.wr(8'h21, 8'h01);
    u_host.wr(8'h22, 8'h03);
    foreach (me[i]) begin
      smp(mx[i], my[i], mz[i], 12'h000);
      flg(me[i], 1'b0);
    end
    rchk(8'h0b, 8'h10);
    rchk(8'h0b, 8'h00);
    // duration zero acts as one
    u_host.wr(8'h22, 8'h00);
    smp(12'h000, 12'h000, 12'h000, 12'h000);
    smp(12'h000, 12'h101, 12'h000, 12'h000);
    flg(1'b1, 1'b0);
    rchk(8'h0b, 8'h10);
    // wake-up mode ignores duration 3
    u_host.wr(8'h22, 8'h03);
    smp(12'h000, 12'h000, 12'h000, 12'h000);
    wake = 1'b1;
    smp(12'h000, 12'h101, 12'h000, 12'h000);
    flg(1'b1, 1'b0);
    wake = 1'b0;
    rchk(8'h0b, 8'h10);
    // upper bits of the high limit byte are ignored
    u_host.wr(8'h20, 8'h10);
    u_host.wr(8'h21, 8'hf8);
    u_host.wr(8'h22, 8'h00);
    smp(12'h000, 12'h000, 12'h000, 12'h000);
    smp(12'h000, 12'h020, 12'h000, 12'h000);
    flg(1'b1, 1'b0);
    rchk(8'h0b, 8'h10);
    // disabled detector stays quiet
    u_host.wr(8'h27, 8'h00);
    repeat (3) smp(12'h000, 12'h101, 12'h000, 12'h000);
    flg(1'b0, 1'b0);
    // stillness run, limit 0x010, duration 2
    u_host.wr(8'h27, 8'h04);
    u_host.wr(8'h23, 8'h10);
    u_host.wr(8'h24, 8'h00);
    u_host.wr(8'h25, 8'h02);
    u_host.wr(8'h26, 8'h00);
    foreach (se[i]) begin
      smp(sx[i], 12'h005, sz[i], 12'h000);
      flg(1'b0, se[i]);
    end
    rchk(8'h0b, 8'h20);
    u_host.wr(8'h25, 8'h00);
    smp(12'h100, 12'h000, 12'h000, 12'h000);
    smp(12'h005, 12'h005, 12'h005, 12'h000);
    flg(1'b0, 1'b1);
    rchk(8'h0b, 8'h20);
    // duration 0x0100 from the high byte
    u_host.wr(8'h26, 8'h01);
    smp(12'h100, 12'h000, 12'h000, 12'h000);
    repeat (255) smp(12'h005, 12'h005, 12'h005, 12'h000);
    flg(1'b0, 1'b0);
    smp(12'h005, 12'h005, 12'h005, 12'h000);
    flg(1'b0, 1'b1);
    // full-scale duration 0xffff, event on the 65535th sample, set beats read
    u_host.wr(8'h25, 8'hff);
    u_host.wr(8'h26, 8'hff);
    smp(12'h100, 12'h000, 12'h000, 12'h000);
    rchk(8'h0b, 8'h20);
    @(negedge clk);
    x = 12'h005;
    y = 12'h005;
    z = 12'h005;
    valid = 1'b1;
    repeat (65533) @(negedge clk);
    chk({6'h0, sflag, mflag}, 8'h00);
    rchk(8'h0b, 8'h00);
    chk({6'h0, sflag, mflag}, 8'h02);
    repeat (4) @(negedge clk);
    valid = 1'b0;
    // keyed reset clears settings and flags
    u_host.wr(8'h1f, 8'h52);
    chk({7'h0, hiz}, 8'h01);
    chk({7'h0, busy}, 8'h00);
    flg(1'b0, 1'b0);
    rchk(8'h27, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h26, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h1f, 8'h00);
    summarize();
  end

endmodule : mdr_regs_tb
